/* rtl/arob_consts.svh */
// register indices, byte addresses, field positions and reset values
`ifndef AROB_CONSTS_SVH
`define AROB_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define AROB_IDX_FLAGS 8'h23
`define AROB_IDX_ANALOG_INPUT_ZERO 8'h24
`define AROB_IDX_ANALOG_INPUT_ONE 8'h25
`define AROB_IDX_TEMP 8'h26
`define AROB_IDX_SDMUX 8'h27
`define AROB_IDX_OFFSET 8'h28
`define AROB_IDX_DAC 8'h2C
`define AROB_IDX_RAW 8'h2D
`define AROB_IDX_BYP 8'h2E

`define AROB_ADDR_FLAGS (`AROB_IDX_FLAGS << 2)
`define AROB_ADDR_ANALOG_INPUT_ZERO (`AROB_IDX_ANALOG_INPUT_ZERO << 2)
`define AROB_ADDR_ANALOG_INPUT_ONE (`AROB_IDX_ANALOG_INPUT_ONE << 2)
`define AROB_ADDR_TEMP (`AROB_IDX_TEMP << 2)
`define AROB_ADDR_SDMUX (`AROB_IDX_SDMUX << 2)
`define AROB_ADDR_OFFSET (`AROB_IDX_OFFSET << 2)
`define AROB_ADDR_DAC (`AROB_IDX_DAC << 2)
`define AROB_ADDR_RAW (`AROB_IDX_RAW << 2)
`define AROB_ADDR_BYP (`AROB_IDX_BYP << 2)

// override control fields
`define AROB_BYP_RESULT_EN_BIT 15
`define AROB_BYP_OFFSET_EN_BIT 14
`define AROB_BYP_GND_DIS_BIT 13
`define AROB_BYP_WRITE_MASK 16'hEFFF

// limit flags: channel code n sits at bit n + 1
`define AROB_FLAG_LSB 1
`define AROB_FLAG_MASK 16'h01FE

`define AROB_RESET_VALUE 16'h0000
`define AROB_RESULT_MAX 12'hFFF

`endif

/* rtl/arob_pkg.sv */
// shared types of the converter result block
package arob_pkg;

  // conversion channels; order fixes the limit-flag bit positions
  typedef enum logic [2:0] {
    AROB_CH_ANALOG_INPUT_ZERO,
    AROB_CH_ANALOG_INPUT_ONE,
    AROB_CH_TEMP,
    AROB_CH_SD0,
    AROB_CH_SD1,
    AROB_CH_SD2,
    AROB_CH_SD3,
    AROB_CH_SD4
  } arob_chan_e;

  // one finished conversion as delivered by the converter
  typedef struct packed {
    arob_chan_e chan;
    logic [11:0] raw;
    logic [11:0] limit_lo;
    logic [11:0] limit_hi;
  } arob_conv_s;

  // corrected result leaving the correction stage
  typedef struct packed {
    arob_chan_e chan;
    logic [11:0] value;
    logic limit_fail;
  } arob_result_s;

  // override settings steering the correction stage
  typedef struct packed {
    logic result_override_enable;
    logic offset_override_enable;
    logic [11:0] bypass_data_field;
  } arob_override_s;

endpackage : arob_pkg

/* rtl/arob_correct.sv */
// offset correction, override and limit check of one conversion
`timescale 1ns/1ns
`include "arob_consts.svh"

module arob_correct (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_valid,
  input wire arob_pkg::arob_conv_s conv,
  input wire logic [11:0] measured_offset,
  input wire arob_pkg::arob_override_s ovr,
  output logic result_valid,
  output arob_pkg::arob_result_s result
);

  logic [11:0] offset_use;
  logic signed [13:0] diff;
  logic [11:0] value_next;

  always_comb begin
    // offset override replaces the measured offset, signed either way
    offset_use = ovr.offset_override_enable ? ovr.bypass_data_field
                                            : measured_offset;
    diff = $signed({2'b00, conv.raw}) - $signed({{2{offset_use[11]}}, offset_use});
    if (ovr.result_override_enable) begin
      value_next = ovr.bypass_data_field;
    end else if (diff < 14'sd0) begin
      value_next = 12'h000;
    end else if (diff > $signed({2'b00, `AROB_RESULT_MAX})) begin
      value_next = `AROB_RESULT_MAX;
    end else begin
      value_next = diff[11:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result <= '0;
    end else begin
      result_valid <= conv_valid;
      if (conv_valid) begin
        result.chan <= conv.chan;
        result.value <= value_next;
        // limits judge the value that software will read back
        result.limit_fail <= (value_next < conv.limit_lo) ||
                             (value_next > conv.limit_hi);
      end
    end
  end

endmodule : arob_correct

/* rtl/arob_top.sv */
// converter result readback, offset correction and override registers
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "arob_consts.svh"


module arob_top #(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONV_DONE,
  input wire arob_pkg::arob_conv_s CONV,
  input wire logic CONV_BUSY,
  input wire logic MEAS_OFFSET_VALID,
  input wire logic [11:0] MEAS_OFFSET,
  input wire logic [15:0] DAC_APPLIED,
  output logic GND_SAMPLE_EN,
  output logic [11:0] OFFSET_EFFECTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] override_ctrl_reg;
  logic [11:0] measured_offset_reg;
  logic [11:0] raw_result_reg;
  logic [15:0] dac_code_reg;
  logic [11:0] input0_reg;
  logic [11:0] input1_reg;
  logic [11:0] temperature_reg;
  logic [11:0] selfdiag_reg;
  logic [7:0] limit_fail_reg;
  arob_pkg::arob_override_s ovr;
  arob_pkg::arob_result_s result;
  logic result_valid;

  always_comb begin
    ovr.result_override_enable = override_ctrl_reg[`AROB_BYP_RESULT_EN_BIT];
    ovr.offset_override_enable = override_ctrl_reg[`AROB_BYP_OFFSET_EN_BIT];
    ovr.bypass_data_field = override_ctrl_reg[11:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, pready raised in the first access cycle

  logic setup_phase;
  logic access_done;
  logic addr_hit;
  logic [31:0] rdata_next;
  logic [15:0] wmask;
  logic [15:0] byp_next;

  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && PREADY;

  always_comb begin
    addr_hit = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (PADDR)
      `AROB_ADDR_FLAGS: begin
        rdata_next[8:1] = limit_fail_reg;
      end
      `AROB_ADDR_ANALOG_INPUT_ZERO: begin
        rdata_next[11:0] = input0_reg;
      end
      `AROB_ADDR_ANALOG_INPUT_ONE: begin
        rdata_next[11:0] = input1_reg;
      end
      `AROB_ADDR_TEMP: begin
        rdata_next[11:0] = temperature_reg;
      end
      `AROB_ADDR_SDMUX: begin
        rdata_next[11:0] = selfdiag_reg;
      end
      `AROB_ADDR_OFFSET: begin
        rdata_next[11:0] = measured_offset_reg;
      end
      `AROB_ADDR_DAC: begin
        rdata_next[15:0] = dac_code_reg;
      end
      `AROB_ADDR_RAW: begin
        rdata_next[11:0] = raw_result_reg;
      end
      `AROB_ADDR_BYP: begin
        rdata_next[15:0] = override_ctrl_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup_phase;
    end
  end

  // read data and error are fixed at setup, before the access edge
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
      PSLVERR <= !addr_hit;
    end else if (access_done) begin
      PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // override control, the only writable register

  always_comb begin
    wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}} & `AROB_BYP_WRITE_MASK;
    byp_next = (override_ctrl_reg & ~wmask) | (PWDATA[15:0] & wmask);
  end

  // software is trusted not to set both enables; if it does, priority decides
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      override_ctrl_reg <= `AROB_RESET_VALUE;
    end else if (access_done && PWRITE && PADDR == `AROB_ADDR_BYP) begin
      override_ctrl_reg <= byp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog side inputs

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      measured_offset_reg <= 12'h000;
    end else if (MEAS_OFFSET_VALID) begin
      // bypass settings never touch the measured value
      measured_offset_reg <= MEAS_OFFSET;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_reg <= 16'h0000;
    end else begin
      // follows the slewing code, not the target
      dac_code_reg <= DAC_APPLIED;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      raw_result_reg <= 12'h000;
    end else if (CONV_DONE) begin
      raw_result_reg <= CONV.raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // correction stage

  arob_correct u_correct (
    .clk(CLOCK),
    .rst_n(rst_n),
    .conv_valid(CONV_DONE),
    .conv(CONV),
    .measured_offset(measured_offset_reg),
    .ovr(ovr),
    .result_valid(result_valid),
    .result(result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readback registers, one per channel group

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      input0_reg <= 12'h000;
    end else if (result_valid && result.chan == arob_pkg::AROB_CH_ANALOG_INPUT_ZERO) begin
      input0_reg <= result.value;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      input1_reg <= 12'h000;
    end else if (result_valid && result.chan == arob_pkg::AROB_CH_ANALOG_INPUT_ONE) begin
      input1_reg <= result.value;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      temperature_reg <= 12'h000;
    end else if (result_valid && result.chan == arob_pkg::AROB_CH_TEMP) begin
      temperature_reg <= result.value;
    end
  end

  // all five diagnostic nodes share one register: last one sampled wins
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      selfdiag_reg <= 12'h000;
    end else if (result_valid && result.chan >= arob_pkg::AROB_CH_SD0) begin
      selfdiag_reg <= result.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit flags: level of the latest check, not sticky

  for (genvar ch = 0; ch < 8; ch++) begin : g_flag
    always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
        limit_fail_reg[ch] <= 1'b0;
      end else if (result_valid && result.chan == arob_pkg::arob_chan_e'(ch)) begin
        limit_fail_reg[ch] <= result.limit_fail;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls

  // ground sampled while idle, registered one cycle behind CONV_BUSY, so it still runs in the first busy cycle
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      GND_SAMPLE_EN <= 1'b0;
    end else begin
      GND_SAMPLE_EN <= !override_ctrl_reg[`AROB_BYP_GND_DIS_BIT] && !CONV_BUSY;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      OFFSET_EFFECTIVE <= 12'h000;
    end else begin
      OFFSET_EFFECTIVE <= ovr.offset_override_enable ? ovr.bypass_data_field
                                                     : measured_offset_reg;
    end
  end

endmodule : arob_top

/* tb/arob_top_sva.sv */
// port-level checks of the converter result block
`timescale 1ns/1ns
`include "arob_consts.svh"
module arob_top_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CONV_BUSY,
  input wire logic [15:0] DAC_APPLIED,
  input wire logic GND_SAMPLE_EN,
  input wire logic [11:0] OFFSET_EFFECTIVE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////////////////////
  logic mapped;
  logic result_reg;
  assign mapped = PADDR inside {`AROB_ADDR_FLAGS, `AROB_ADDR_ANALOG_INPUT_ZERO, `AROB_ADDR_ANALOG_INPUT_ONE,
    `AROB_ADDR_TEMP, `AROB_ADDR_SDMUX, `AROB_ADDR_OFFSET, `AROB_ADDR_DAC, `AROB_ADDR_RAW,
    `AROB_ADDR_BYP};
  assign result_reg = PADDR inside {`AROB_ADDR_ANALOG_INPUT_ZERO, `AROB_ADDR_ANALOG_INPUT_ONE, `AROB_ADDR_TEMP,
    `AROB_ADDR_SDMUX, `AROB_ADDR_OFFSET, `AROB_ADDR_RAW};
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence done_s;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence byp_wr_s;
    done_s ##0 (PWRITE && PADDR == `AROB_ADDR_BYP && PSTRB == 4'hF);
  endsequence
  property ofs_follow_p;
    logic [11:0] d;
    (byp_wr_s ##0 (PWDATA[14], d = PWDATA[11:0])) |-> ##[1:2] OFFSET_EFFECTIVE == d;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  ready_after_setup_a: assert property (setup_s |=> PREADY)
    else $error("no ready after setup");
  ready_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  upper_half_zero_a: assert property (done_s |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");
  slverr_map_a: assert property (done_s |-> PSLVERR == !mapped)
    else $error("error flag does not match map");
  flags_reserved_a: assert property (
    done_s ##0 (!PWRITE && PADDR == `AROB_ADDR_FLAGS) |-> PRDATA[15:9] == 7'h00 && !PRDATA[0])
    else $error("reserved flag bits set");
  result_upper_a: assert property (
    done_s ##0 (!PWRITE && result_reg) |-> PRDATA[15:12] == 4'h0)
    else $error("result upper bits set");
  dac_mirror_a: assert property (
    ($stable(DAC_APPLIED) [*3]) ##0 done_s ##0 (!PWRITE && PADDR == `AROB_ADDR_DAC)
    |-> PRDATA[15:0] == DAC_APPLIED) else $error("dac mirror wrong");
  offset_follow_a: assert property (ofs_follow_p)
    else $error("effective offset not bypass data");
  gnd_busy_a: assert property (CONV_BUSY |=> !GND_SAMPLE_EN)
    else $error("ground sampling while busy");
  gnd_disable_a: assert property (byp_wr_s ##0 PWDATA[13] |-> ##2 !GND_SAMPLE_EN)
    else $error("ground sampling not disabled");
endmodule : arob_top_sva

/* tb/tb_arob_top.sv */
// self-checking bench of the converter result block
`timescale 1ns/1ns
`include "arob_consts.svh"
module tb_arob_top;
  logic clock, arst_n, psel, penable, pwrite, conv_done, conv_busy, meas_valid;
  logic pready, pslverr, gnd_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [11:0] meas_offset, ofs_eff, meas, rawm;
  logic [11:0] res [4];
  logic [15:0] dac, ovr, flags;
  logic [17:0] n;
  logic [17:0] q [$];
  arob_pkg::arob_conv_s conv;
  int miscompares, samples_checked;
  arob_top #(.ADDR_W(8)) DUT (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CONV_DONE(conv_done),
    .CONV(conv), .CONV_BUSY(conv_busy), .MEAS_OFFSET_VALID(meas_valid),
    .MEAS_OFFSET(meas_offset), .DAC_APPLIED(dac), .GND_SAMPLE_EN(gnd_en),
    .OFFSET_EFFECTIVE(ofs_eff));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // note goes in first; the monitor pops it at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic [15:0] e, input logic err);
    q.push_back({w, err, e});
    @(posedge clock) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0, d};
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (!pready);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(0, a, 16'h0, e, 0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1, a, d, 16'h0, 0);
    if (a == `AROB_ADDR_BYP) ovr = d & `AROB_BYP_WRITE_MASK;
  endtask : wr
  // one conversion, with the expected readback worked out alongside
  task automatic cv(input int ch, input logic [11:0] raw, lo, hi);
    int v;
    v = int'(raw) - int'($signed(ovr[14] ? ovr[11:0] : meas));
    v = ovr[15] ? int'(ovr[11:0]) : (v < 0 ? 0 : (v > 4095 ? 4095 : v));
    flags[ch + 1] = (v < lo) || (v > hi);
    res[ch > 2 ? 3 : ch] = v[11:0];
    rawm = raw;
    @(posedge clock) {conv_done, conv} <= {1'b1, 3'(ch), raw, lo, hi};
    @(posedge clock) conv_done <= 0;
    @(posedge clock);
  endtask : cv
  task automatic check_all;
    rd(`AROB_ADDR_FLAGS, flags);
    rd(`AROB_ADDR_ANALOG_INPUT_ZERO, {4'h0, res[0]});
    rd(`AROB_ADDR_ANALOG_INPUT_ONE, {4'h0, res[1]});
    rd(`AROB_ADDR_TEMP, {4'h0, res[2]});
    rd(`AROB_ADDR_SDMUX, {4'h0, res[3]});
    rd(`AROB_ADDR_OFFSET, {4'h0, meas});
    rd(`AROB_ADDR_RAW, {4'h0, rawm});
  endtask : check_all
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      n = q.pop_front();
      chk("slverr", {31'h0, n[16]}, {31'h0, pslverr});
      if (!n[17]) chk("prdata", {16'h0, n[15:0]}, prdata);
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, conv_done, conv_busy} = '0;
    {meas_valid, meas_offset, dac, ovr, flags, meas, rawm, conv} = '0;
    pstrb = 4'hF;
    res = '{default: 12'h000};
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'hC30A));
    repeat (8) @(posedge clock);
    arst_n <= 1;
    repeat (3) @(posedge clock);
    wr(`AROB_ADDR_FLAGS, 16'hFFFF);
    check_all();
    rd(`AROB_ADDR_DAC, 16'h0000);
    apb(0, 8'h00, 16'h0, 16'h0, 1);
    $display("test reset values done");
    wr(`AROB_ADDR_BYP, 16'hFFFF);
    rd(`AROB_ADDR_BYP, 16'hEFFF);
    repeat (2) @(posedge clock);
    chk("gnd", 0, {31'h0, gnd_en});
    wr(`AROB_ADDR_BYP, 16'h0000);
    repeat (2) @(posedge clock);
    chk("gnd", 1, {31'h0, gnd_en});
    conv_busy <= 1;
    repeat (2) @(posedge clock);
    chk("gnd", 0, {31'h0, gnd_en});
    conv_busy <= 0;
    // only the low byte lane carries data here
    pstrb <= 4'h1;
    wr(`AROB_ADDR_BYP, 16'hFF5A);
    pstrb <= 4'hF;
    ovr = 16'h005A;
    rd(`AROB_ADDR_BYP, 16'h005A);
    $display("test override register done");
    // positive offset so that a zero sample saturates low
    @(posedge clock) {meas_valid, meas_offset} <= {1'b1, 12'h010};
    @(posedge clock) meas_valid <= 0;
    meas = 12'h010;
    cv(0, 12'h000, 12'h000, 12'hFFF);
    chk("ofs_eff", 32'h010, {20'h0, ofs_eff});
    for (int ch = 0; ch < 8; ch++) begin
      cv(ch, 12'($urandom), 12'($urandom_range(0, 2047)), 12'($urandom_range(2048, 4095)));
      check_all();
    end
    $display("test offset correction done");
    wr(`AROB_ADDR_BYP, 16'h4FF0);
    repeat (2) @(posedge clock);
    chk("ofs_eff", 32'hFF0, {20'h0, ofs_eff});
    cv(0, 12'hFFF, 12'h000, 12'h800);
    cv(3, 12'($urandom), 12'h100, 12'hF00);
    check_all();
    wr(`AROB_ADDR_BYP, 16'h8ABC);
    cv(1, 12'($urandom), 12'h000, 12'h800);
    check_all();
    wr(`AROB_ADDR_BYP, 16'hC123);
    cv(2, 12'($urandom), 12'h200, 12'hFFF);
    check_all();
    $display("test overrides done");
    dac <= 16'($urandom);
    repeat (3) @(posedge clock);
    rd(`AROB_ADDR_DAC, dac);
    $display("test dac mirror done");
    print_verdict();
  end
endmodule : tb_arob_top
bind arob_top arob_top_sva #(.ADDR_W(ADDR_W)) u_sva (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CONV_BUSY(CONV_BUSY), .DAC_APPLIED(DAC_APPLIED), .GND_SAMPLE_EN(GND_SAMPLE_EN),
  .OFFSET_EFFECTIVE(OFFSET_EFFECTIVE));
